// >>> design/bc_block_status_word.sv
// Summary of operation
// - Set done flag at every message end
// - Capture time tag when done flag sets
// - Active flag set at start, cleared end
// - Capture time tag on active set, clear
// - Bus flag one for bus B, zero A
// - Write finished status word to RAM
// - Check format only when enable bit set
// - Compare control flags against command words
// - Mismatch sets the format mismatch flag
// - All four flags reset to zero
`timescale 1ns/1ps
module bc_block_status_word
(
    input wire logic clk, // 20 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic msg_start, // One-cycle pulse, message begins
    input wire logic msg_end, // One-cycle pulse, message ends
    input wire logic on_bus_b, // Level, message runs on bus B
    input wire logic [15:0] bc_config, // Controller configuration register
    input wire logic [15:0] control_word, // Message control word
    input wire logic [15:0] cmd_word_1, // First command word
    input wire logic [15:0] cmd_word_2, // Second command word, RT-RT only
    input wire logic [31:0] time_tag, // Live time-tag count
    input wire logic [15:0] other_status, // Status bits 11..0 from elsewhere
    output logic [15:0] status_word, // Live block status word
    output logic [31:0] tag_snapshot, // Captured time tag
    output logic tag_write, // Pulse, write snapshot to RAM
    output logic word_write, // Pulse, write status word to RAM
    output logic [15:0] ram_wdata // Word for the RAM write
);
    import bsw_pkg::*;

    // Timing of one message, counted in clock edges:
    //   c0    start pulse taken; flags open and the time tag is caught
    //   c1    tag strobe with the start snapshot; flags show active
    //   c2    live word shows active and the bus of this message
    //   cN    end pulse taken; done sets, active clears, tag caught again
    //   cN+1  tag strobe with the end snapshot; sequencer in write state
    //   cN+2  word strobe with the finished word; live word shows done
    // A new start is taken from cN+2 on, once the sequencer is idle again.
    //
    // The bus flag and the mismatch flag are frozen at the start edge, so
    // the inputs that feed them only need to be valid with the start pulse.
    // The low twelve bits are not latched here: they must already hold the
    // final status of the message by the time the word is stored.
    //
    // Limitation: a second start that comes while a message runs is lost
    // without trace; the sequencer that drives this block must not do it.
    // Trade-off: the stored word waits one extra cycle after the end so
    // that it is built from settled flags rather than from the end pulse.

    // Sequencer state and its next value
    bsw_state_t state;
    bsw_state_t next_state;

    // The four flags owned here; lower bits are passed through untouched
    logic done_flag;
    logic active_flag;
    logic bus_flag;
    logic mismatch_flag;

    // Does a command word address every terminal
    function automatic logic is_bcast(input logic [15:0] cw);
        is_bcast = (cw[CMD_ADDR_HI:CMD_ADDR_LO] == BCAST_ADDR);
    endfunction : is_bcast

    // Does a command word carry a mode code; both subaddress encodings count
    function automatic logic is_mode(input logic [15:0] cw);
        is_mode = (cw[CMD_SUB_HI:CMD_SUB_LO] == MODE_SUB_A)
            || (cw[CMD_SUB_HI:CMD_SUB_LO] == MODE_SUB_B);
    endfunction : is_mode

    // Lay the owned flags over the passed-in low bits
    function automatic logic [15:0] pack_word
    (
        input logic done,
        input logic active,
        input logic bus,
        input logic mismatch,
        input logic [15:0] other
    );
        pack_word = other & OTHER_MASK;
        pack_word[DONE_BIT] = done;
        pack_word[ACTIVE_BIT] = active;
        pack_word[BUS_BIT] = bus;
        pack_word[MISMATCH_BIT] = mismatch;
    endfunction : pack_word

    // Format check switch, sampled only on the start edge
    wire logic check_on = bc_config[FMT_CHECK_BIT];

    // What the control word claims about the message
    wire logic want_mode = control_word[CW_MODE_BIT];
    wire logic want_rtrt = control_word[CW_RTRT_BIT];
    wire logic want_bcst = control_word[CW_BCST_BIT];

    // What the command words actually say
    wire logic cmd1_mode = is_mode(cmd_word_1);
    wire logic cmd1_bcst = is_bcast(cmd_word_1);
    wire logic cmd2_mode = is_mode(cmd_word_2);

    // Mode and broadcast are judged on the first command only; the second
    // command of an RT-RT pair is looked at just for a stray mode code
    wire logic mode_bad = want_mode != cmd1_mode;
    wire logic bcst_bad = want_bcst != cmd1_bcst;
    wire logic rtrt_bad = want_rtrt && cmd2_mode;

    // With the check off the flag stays clear instead of holding a stale result
    wire logic any_bad = mode_bad || bcst_bad || rtrt_bad;
    wire logic format_bad = check_on && any_bad;

    // State decode
    wire logic in_idle = (state == ST_IDLE);
    wire logic in_run = (state == ST_RUN);
    wire logic in_write = (state == ST_WRITE);

    // Pulses only count in the state that expects them; strays are dropped
    // so that a stray start cannot reopen a message during the store
    wire logic starting = in_idle && msg_start;
    wire logic ending = in_run && msg_end;

    // The time tag is caught on both edges of the active flag
    wire logic capture_tag = starting || ending;

    // Next flag values; a start opens a fresh message, an end closes it
    wire logic next_done = starting ? 1'b0 : (ending ? 1'b1 : done_flag);
    wire logic next_active = starting ? 1'b1 : (ending ? 1'b0 : active_flag);
    wire logic next_bus = starting ? on_bus_b : bus_flag;
    wire logic next_mismatch = starting ? format_bad : mismatch_flag;

    // Word as the flags stand now; in the write state done is set, active clear
    wire logic [15:0] next_status = pack_word(done_flag, active_flag, bus_flag,
        mismatch_flag, other_status);

    // Sequencer: a start while busy is ignored, an end only counts in run
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (msg_start)
                begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (msg_end)
                begin
                    next_state = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // One register per flag keeps each process short and each reset
    // value visible at a glance; all four clear together on reset.

    // End-of-message flag, cleared again only by the next start
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done_flag <= 1'b0;
        end
        else
        begin
            done_flag <= next_done;
        end
    end

    // Start-of-message flag, high while the message runs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            active_flag <= 1'b0;
        end
        else
        begin
            active_flag <= next_active;
        end
    end

    // Bus flag, frozen at the start edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_flag <= 1'b0;
        end
        else
        begin
            bus_flag <= next_bus;
        end
    end

    // Format mismatch flag, frozen at the start edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mismatch_flag <= 1'b0;
        end
        else
        begin
            mismatch_flag <= next_mismatch;
        end
    end

    // Every output below comes straight from a flip-flop, so the RAM port
    // sees clean strobes; the cost is one cycle of latency on each of them.

    // Live status word, one cycle behind the flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_word <= WORD_RESET;
        end
        else
        begin
            status_word <= next_status;
        end
    end

    // Tag strobe, one cycle after the start or end edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tag_write <= 1'b0;
        end
        else
        begin
            tag_write <= capture_tag;
        end
    end

    // Snapshot holds between captures so the value under the strobe is stable
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tag_snapshot <= TAG_RESET;
        end
        else if (capture_tag)
        begin
            tag_snapshot <= time_tag;
        end
    end

    // Word strobe in the cycle after the write state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            word_write <= 1'b0;
        end
        else
        begin
            word_write <= in_write;
        end
    end

    // Finished word, built from the settled flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ram_wdata <= WORD_RESET;
        end
        else if (in_write)
        begin
            ram_wdata <= next_status;
        end
    end
endmodule : bc_block_status_word

// >>> design/bsw_pkg.sv
package bsw_pkg;
    // Bit positions inside the block status word
    localparam int unsigned DONE_BIT = 15;
    localparam int unsigned ACTIVE_BIT = 14;
    localparam int unsigned BUS_BIT = 13;
    localparam int unsigned MISMATCH_BIT = 12;
    // Format check enable sits at this bit of the controller configuration
    localparam int unsigned FMT_CHECK_BIT = 13;
    // Control word format flag positions
    localparam int unsigned CW_MODE_BIT = 2;
    localparam int unsigned CW_RTRT_BIT = 1;
    localparam int unsigned CW_BCST_BIT = 0;
    // Command word fields
    localparam int unsigned CMD_ADDR_HI = 15;
    localparam int unsigned CMD_ADDR_LO = 11;
    localparam int unsigned CMD_SUB_HI = 9;
    localparam int unsigned CMD_SUB_LO = 5;
    localparam logic [4:0] BCAST_ADDR = 5'h1F;
    localparam logic [4:0] MODE_SUB_A = 5'h00;
    localparam logic [4:0] MODE_SUB_B = 5'h1F;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Low status bits owned by other logic and passed through as they are
    localparam logic [15:0] OTHER_MASK = 16'h0FFF;
    localparam logic [31:0] TAG_RESET = 32'h00000000;
    // Sequencer states, Gray coded along idle, run, write
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WRITE = 2'b11
    } bsw_state_t;
endpackage : bsw_pkg

// >>> test/bsw_properties.sv
`timescale 1ns/1ps
module bsw_properties (
    input wire logic clk, rst, msg_start, msg_end, on_bus_b, tag_write, word_write,
    input wire logic [15:0] bc_config, control_word, cmd_word_1, status_word, ram_wdata,
    input wire logic [31:0] time_tag, tag_snapshot
);
    import bsw_pkg::*;
    logic run, wr;
    // Only pulses the block would take arm a check; refused ones are ignored
    wire go = msg_start && !run && !wr;
    wire fin = msg_end && run;
    always_ff @(posedge clk)
    begin
        run <= !rst && (go || (run && !msg_end));
        wr <= !rst && fin;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_S_TAG: assert property (go |=> tag_write && tag_snapshot == $past(time_tag))
        else $error("start tag");
    AST_E_TAG: assert property (fin |=> tag_write && tag_snapshot == $past(time_tag))
        else $error("end tag");
    AST_ACT: assert property (go |=> ##1 status_word[15:14] == 2'h1)
        else $error("active flag");
    AST_BUS: assert property (go |=> ##1 status_word[13] == $past(on_bus_b, 2))
        else $error("bus flag");
    AST_STORE: assert property (fin |=> ##1 word_write && ram_wdata[15:14] == 2'h2)
        else $error("word store");
    AST_DONE: assert property (fin |=> ##1 status_word[15:14] == 2'h2)
        else $error("done flag");
    AST_MM: assert property (go && bc_config[13] && control_word[2:0] == 3'h1 &&
        cmd_word_1[15:11] != 5'h1F |=> ##1 status_word[12]) else $error("mismatch");
    AST_FMT_OFF: assert property (go && !bc_config[13] |=> ##1 !status_word[12])
        else $error("check off");
    AST_RST: assert property ($past(rst) |-> status_word == 0 && !tag_write && !word_write)
        else $error("reset");
    cover property (go && bc_config[13]);
    cover property (fin);
    cover property (word_write && go);
endmodule : bsw_properties
bind bc_block_status_word bsw_properties chk (.clk(clk), .rst(rst), .msg_start(msg_start),
    .msg_end(msg_end), .on_bus_b(on_bus_b), .tag_write(tag_write), .word_write(word_write),
    .bc_config(bc_config), .control_word(control_word), .cmd_word_1(cmd_word_1),
    .status_word(status_word), .ram_wdata(ram_wdata), .time_tag(time_tag),
    .tag_snapshot(tag_snapshot));

// >>> test/host_ram.sv
`timescale 1ns/1ps
module host_ram (input wire logic clk, word_write, tag_write, input wire logic [15:0] ram_wdata,
    input wire logic [31:0] tag_snapshot, output logic [15:0] bsw_mem, output logic [31:0] tag_mem);
    // Host copy is only read back, never written by the host
    always_ff @(posedge clk) if (word_write) bsw_mem <= ram_wdata;
    always_ff @(posedge clk) if (tag_write) tag_mem <= tag_snapshot;
endmodule : host_ram

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, msg_start = 0, msg_end = 0, on_bus_b = 0;
    logic [15:0] bc_config = 0, control_word = 0, cmd_word_1 = 16'h2860, cmd_word_2 = 0;
    logic [15:0] other_status = 0, status_word, ram_wdata, bsw_mem, wq[$];
    logic [31:0] time_tag = 0, tag_snapshot, tag_mem, tq[$];
    logic tag_write, word_write;
    int n_errors = 0, checks_done = 0;
    always #25 clk = ~clk;
    bc_block_status_word dut (.clk(clk), .rst(rst), .msg_start(msg_start), .msg_end(msg_end),
        .on_bus_b(on_bus_b), .bc_config(bc_config), .control_word(control_word),
        .cmd_word_1(cmd_word_1), .cmd_word_2(cmd_word_2), .time_tag(time_tag),
        .other_status(other_status), .status_word(status_word), .tag_snapshot(tag_snapshot),
        .tag_write(tag_write), .word_write(word_write), .ram_wdata(ram_wdata));
    host_ram host (.clk(clk), .word_write(word_write), .tag_write(tag_write),
        .ram_wdata(ram_wdata), .tag_snapshot(tag_snapshot), .bsw_mem(bsw_mem),
        .tag_mem(tag_mem));
    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin n_errors++; $display("Error %0t: %h not %h", $time, seen, exp); end
    endtask : check
    task automatic wrap_up;
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // One message; mode flag vs subaddress 0/31, broadcast flag vs address 31,
    // RT-RT flag with a mode code in the second command: each is a coding error
    task automatic run_msg(input int gap);
        logic m;
        on_bus_b = $urandom;
        bc_config = $urandom;
        other_status = $urandom;
        control_word = {13'h0000, 3'($urandom)};
        cmd_word_1 = $urandom;
        cmd_word_2 = $urandom;
        if ($urandom_range(0, 1)) cmd_word_1[15:11] = 5'h1F;
        if ($urandom_range(0, 1)) cmd_word_1[9:5] = {5{1'($urandom)}};
        if ($urandom_range(0, 1)) cmd_word_2[9:5] = {5{1'($urandom)}};
        m = (control_word[2] != (cmd_word_1[9:5] inside {5'h00, 5'h1F}))
            || (control_word[0] != (cmd_word_1[15:11] == 5'h1F))
            || (control_word[1] && (cmd_word_2[9:5] inside {5'h00, 5'h1F}));
        time_tag = $urandom;
        tq.push_back(time_tag);
        wq.push_back({2'h2, on_bus_b, bc_config[13] & m, other_status[11:0]});
        msg_start = 1;
        #50 msg_start = 0;
        repeat (gap) #50;
        time_tag = $urandom;
        tq.push_back(time_tag);
        msg_end = 1;
        #50 msg_end = 0;
        #50;
    endtask : run_msg
    // Each host-side store is matched to the oldest note
    always @(posedge clk) if (word_write === 1'b1) begin @(negedge clk);
        check(bsw_mem, wq.pop_front()); end
    always @(posedge clk) if (tag_write === 1'b1) begin @(negedge clk);
        check(tag_mem, tq.pop_front()); end
    initial
    begin
        void'($urandom(65));
        repeat (3) @(posedge clk);
        #1 rst = 0;
        check(status_word, 0);
        // An end while idle must leave no store behind
        msg_end = 1;
        #50 msg_end = 0;
        repeat (30) run_msg($urandom_range(0, 3));
        #200 wrap_up;
    end
    initial
    begin
        #30000 n_errors++;
        wrap_up;
    end
endmodule : testbench
